// File: bench/event_out_chk_sva.sv
// ================================================================
// port checker for the event output matcher
module event_out_chk (
    // watched ports
    input wire logic                              clk, rst, cfg_wr, log_valid, log_set,
    input wire logic                              cmd_status_level, scada_level,
    input wire logic                              out_drive, cfg_reject, event_active,
    input wire logic [1:0]                        cfg_usage, cur_usage,
    input wire logic [event_out_pkg::PARAM_W-1:0] cfg_param, cur_param
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // a disabled output never drives, whatever is logged
    property p_dis_low; cur_usage == event_out_pkg::USAGE_DISABLED [*2] |-> !out_drive; endproperty
    a_dis_low: assert property (p_dis_low) else $error("disabled output driven");
    property p_cmd; cur_usage == event_out_pkg::USAGE_CMD_STATUS [*2]
        |-> out_drive == $past(cmd_status_level); endproperty
    a_cmd: assert property (p_cmd) else $error("command level not followed");
    property p_scada; cur_usage == event_out_pkg::USAGE_SCADA [*2]
        |-> out_drive == $past(scada_level); endproperty
    a_scada: assert property (p_scada) else $error("link level not followed");
    property p_tracks; cur_usage == event_out_pkg::USAGE_SYS_EVENT [*3]
        |-> out_drive == event_active; endproperty
    a_tracks: assert property (p_tracks) else $error("pin differs from active flag");
    property p_refuse; cfg_wr && cfg_usage == event_out_pkg::USAGE_SYS_EVENT && cfg_param > 6'h2E
        |=> cfg_reject && cur_param == $past(cur_param); endproperty
    a_refuse: assert property (p_refuse) else $error("bad index not refused");
    property p_other; cfg_wr && cfg_usage != event_out_pkg::USAGE_SYS_EVENT
        |=> !cfg_reject && cur_usage == $past(cfg_usage); endproperty
    a_other: assert property (p_other) else $error("usage write not taken");
    property p_nowr; !cfg_wr |=> !cfg_reject; endproperty
    a_nowr: assert property (p_nowr) else $error("refusal without write");
    // wildcard: any set entry raises the pin three edges later
    property p_any; log_valid && log_set && !cfg_wr && cur_usage == event_out_pkg::USAGE_SYS_EVENT
        && cur_param == event_out_pkg::ANY_SPN_INDEX ##1 !cfg_wr |-> ##2 out_drive && event_active;
    endproperty
    a_any: assert property (p_any) else $error("wildcard entry missed");
    property p_idle; cur_usage != event_out_pkg::USAGE_SYS_EVENT [*4] |-> !event_active; endproperty
    a_idle: assert property (p_idle) else $error("active flag outside event usage");
endmodule // event_out_chk

bind system_event_output_matcher event_out_chk u_chk (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
    .log_valid(log_valid), .log_set(log_set), .cmd_status_level(cmd_status_level),
    .scada_level(scada_level), .out_drive(out_drive), .cfg_reject(cfg_reject),
    .event_active(event_active), .cfg_usage(cfg_usage), .cur_usage(cur_usage),
    .cfg_param(cfg_param), .cur_param(cur_param));

// File: bench/relay_load.sv
// ================================================================
// load on the relay contact: picks up one cycle after the coil drive
module relay_load (
    input  wire logic clk,
    input  wire logic pin,        // coil drive from the output
    output logic      energized   // contact state seen by the load
);
    timeunit 1ns;
    timeprecision 1ps;
    // a real coil lags its drive; one cycle stands in for that lag
    always_ff @(posedge clk) energized <= pin;
endmodule // relay_load

// File: bench/test_system_event_output_matcher.sv
// ================================================================
// bench: drives at the falling edge, models the log count with integers
module test_system_event_output_matcher;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, cfg_wr, cmd_status_level, scada_level, log_valid, log_set, lvl;
    logic out_drive, cfg_reject, event_active, energized;
    logic [1:0] cfg_usage, cur_usage;
    logic [event_out_pkg::PARAM_W-1:0] cfg_param, cur_param;
    logic [event_out_pkg::FMI_W-1:0] cfg_fmi, log_fmi, cur_fmi;
    logic [event_out_pkg::SPN_W-1:0] log_spn;
    int error_cnt = 0, n_tests = 0, cyc = 0, cnt = 0, m_use = 0, m_spn = 0, m_fmi = 0;
    int m_par = 0;  // model of the stored parameter index
    integer seed = 32'hb1a9_03ef;
    // rows: table index, number, supported code, unsupported code
    int tab [28][4] = '{'{0,100,14,0}, '{1,1390,15,3}, '{2,110,4,1}, '{3,175,17,3},
        '{4,173,0,14}, '{5,1122,1,31}, '{6,1124,15,1}, '{7,111,1,14},
        '{8,98,0,31}, '{9,96,17,6}, '{10,38,15,11}, '{12,1231,11,17},
        '{13,167,17,11}, '{14,168,0,1}, '{15,970,31,0}, '{16,4006,31,17},
        '{17,1664,31,0}, '{36,701,31,0}, '{43,708,31,6}, '{46,4158,6,31},
        '{44,1083,0,2}, '{34,4013,6,0}, '{35,4004,31,17}, '{20,2448,15,2},
        '{21,2436,12,31}, '{22,2452,1,0}, '{24,639,11,31}, '{25,3581,11,0}};

    system_event_output_matcher #(.CNT_W(4)) u_dut (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
        .cfg_usage(cfg_usage), .cfg_param(cfg_param), .cfg_fmi(cfg_fmi),
        .cmd_status_level(cmd_status_level), .scada_level(scada_level), .log_valid(log_valid),
        .log_set(log_set), .log_spn(log_spn), .log_fmi(log_fmi), .out_drive(out_drive),
        .cfg_reject(cfg_reject), .cur_usage(cur_usage), .cur_param(cur_param),
        .cur_fmi(cur_fmi), .event_active(event_active));
    relay_load u_load (.clk(clk), .pin(out_drive), .energized(energized));

    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    // hang guard: the whole run needs about 1330 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            complete_run();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one write; a refused write leaves the model untouched; s < 0 means any number
    task cfg(input int u, input int p, input int f, input int rej, input int s);
        @(negedge clk);
        cfg_wr = 1; cfg_usage = 2'(u); cfg_param = 6'(p); cfg_fmi = 5'(f);
        @(negedge clk);
        cfg_wr = 0;
        chk(cfg_reject, rej[0]);
        if (!rej) begin
            cnt = 0; m_use = u; m_spn = s;
            if (u == 2) begin
                m_fmi = f;
                m_par = p;
            end
        end
        chk(cur_usage, m_use);
        chk(cur_param, m_par);
        chk(cur_fmi, m_fmi);
        repeat (2) @(negedge clk);  // keeps entries clear of the flush
    endtask
    // one log entry, then the pin three edges later
    task log_ev(input int s, input int spn, input int f);
        @(negedge clk);
        log_valid = 1; log_set = s[0]; log_spn = 19'(spn); log_fmi = 5'(f);
        if (m_use == 2 && (m_spn < 0 || (spn == m_spn && f == m_fmi)))
            cnt = s ? cnt + 1 : (cnt > 0 ? cnt - 1 : 0);
        @(negedge clk);
        log_valid = 0;
        repeat (3) @(negedge clk);
        chk(out_drive, m_use == 2 && cnt > 0);
        chk(event_active, m_use == 2 && cnt > 0);
        // the contact follows the pin one edge later
        @(negedge clk);
        chk(energized, m_use == 2 && cnt > 0);
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        rst = 1; cfg_wr = 0; cfg_usage = 0; cfg_param = 0; cfg_fmi = 0; lvl = 0;
        cmd_status_level = 0; scada_level = 0; log_valid = 0; log_set = 0; log_spn = 0; log_fmi = 0;
        repeat (5) @(negedge clk);
        rst = 0;
        chk(out_drive, 0);
        foreach (tab[i]) begin
            cfg(2, tab[i][0], tab[i][3], 1, 0);
            cfg(2, tab[i][0], tab[i][2], 0, tab[i][1]);
            log_ev(1, tab[i][1] + 1, tab[i][2]);
            log_ev(1, tab[i][1], tab[i][3]);
            repeat (2) log_ev(1, tab[i][1], tab[i][2]);
            repeat (2) log_ev(0, tab[i][1], tab[i][2]);
        end
        $display("selection table done");
        cfg(2, 6'h2F, 0, 1, 0);
        cfg(2, 6'h3F, 31, 1, 0);
        cfg(2, 11, 7, 0, -1);
        repeat (3) log_ev(1, $random(seed) & 19'h7_FFFF, $random(seed) & 5'h1F);
        repeat (3) log_ev(0, $random(seed) & 19'h7_FFFF, $random(seed) & 5'h1F);
        $display("wildcard done");
        for (int u = 1; u <= 3; u += 2) begin
            cfg(u, 0, 0, 0, 0);
            lvl = 0;
            cmd_status_level = 0;
            scada_level = 0;
            repeat (12) begin
                @(negedge clk);
                chk(out_drive, lvl);
                lvl = 1'($random(seed));
                if (u == 1) cmd_status_level = lvl;
                else scada_level = lvl;
            end
        end
        $display("level usages done");
        cfg(0, 0, 0, 0, 0);
        log_ev(1, 100, 1);
        $display("disabled done");
        complete_run();
    end
endmodule // test_system_event_output_matcher

// File: verilog/active_event_counter.sv
// ======================================================================
// number of matching entries still active in the log
module active_event_counter #(
    parameter int CNT_W = event_out_pkg::CNT_W
) (
    // clock and reset
    input  logic             clk,
    input  logic             rst,
    // control
    input  logic             flush,   // selection changed, forget all
    input  logic             up,
    input  logic             down,
    // state
    output logic [CNT_W-1:0] count
);

    logic [CNT_W-1:0] count_next;

    // ==================================================================
    // saturating both ways: a clear with no known set is ignored, and
    // sets past the top are dropped, so later clears can empty it early
    always_comb begin
        count_next = count;
        if (flush) begin
            count_next = '0;
        end else if (up && !down && (count != {CNT_W{1'b1}})) begin
            count_next = count + 1'b1;
        end else if (down && !up && (count != '0)) begin
            count_next = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= count_next;
        end
    end

endmodule // active_event_counter

// File: verilog/event_out_pkg.sv
package event_out_pkg;

    // ==================================================================
    // widths
    localparam int SPN_W   = 19;  // suspect parameter number width
    localparam int FMI_W   = 5;   // failure mode identifier width
    localparam int PARAM_W = 6;   // event parameter selector width
    localparam int CNT_W   = 4;   // active event counter width

    // ==================================================================
    // usage selection codes
    localparam logic [1:0] USAGE_DISABLED   = 2'h0;
    localparam logic [1:0] USAGE_CMD_STATUS = 2'h1;
    localparam logic [1:0] USAGE_SYS_EVENT  = 2'h2;
    localparam logic [1:0] USAGE_SCADA      = 2'h3;

    // ==================================================================
    // reset values of the stored configuration
    localparam logic [1:0]         RST_USAGE = USAGE_DISABLED;
    localparam logic [PARAM_W-1:0] RST_PARAM = 6'h00;
    localparam logic [FMI_W-1:0]   RST_FMI   = 5'h00;

    // ==================================================================
    // event parameter table: number of entries and the wildcard entry
    localparam logic [PARAM_W-1:0] PARAM_COUNT   = 6'h30;
    localparam logic [PARAM_W-1:0] ANY_SPN_INDEX = 6'h0B;

    // ==================================================================
    // one bit per supported trigger code, indexed by the code itself
    localparam logic [31:0] FM00 = 32'h0000_0001;
    localparam logic [31:0] FM01 = 32'h0000_0002;
    localparam logic [31:0] FM02 = 32'h0000_0004;
    localparam logic [31:0] FM03 = 32'h0000_0008;
    localparam logic [31:0] FM04 = 32'h0000_0010;
    localparam logic [31:0] FM05 = 32'h0000_0020;
    localparam logic [31:0] FM06 = 32'h0000_0040;
    localparam logic [31:0] FM09 = 32'h0000_0200;
    localparam logic [31:0] FM11 = 32'h0000_0800;
    localparam logic [31:0] FM12 = 32'h0000_1000;
    localparam logic [31:0] FM14 = 32'h0000_4000;
    localparam logic [31:0] FM15 = 32'h0000_8000;
    localparam logic [31:0] FM17 = 32'h0002_0000;
    localparam logic [31:0] FM31 = 32'h8000_0000;

endpackage

// File: verilog/log_entry_matcher.sv
// ======================================================================
// compares one event log entry with the stored selection
module log_entry_matcher #(
    parameter int SPN_W = event_out_pkg::SPN_W,
    parameter int FMI_W = event_out_pkg::FMI_W
) (
    // clock and reset
    input  logic             clk,
    input  logic             rst,
    // stored selection
    input  logic             armed,      // usage is system event
    input  logic             any_spn,    // wildcard selection
    input  logic [SPN_W-1:0] sel_spn,
    input  logic [FMI_W-1:0] sel_fmi,
    // event log entry
    input  logic             log_valid,
    input  logic             log_set,    // high logged, low cleared
    input  logic [SPN_W-1:0] log_spn,
    input  logic [FMI_W-1:0] log_fmi,
    // one-cycle results
    output logic             hit_set,
    output logic             hit_clear
);

    logic hit;             // combinational match of the entry
    logic hit_set_next;
    logic hit_clear_next;

    // ==================================================================
    // wildcard ignores both codes; otherwise both must agree
    always_comb begin
        hit = armed & log_valid & (any_spn | ((log_spn == sel_spn) & (log_fmi == sel_fmi)));
        hit_set_next   = hit & log_set;
        hit_clear_next = hit & ~log_set;
    end

    // registering breaks the long compare path before the counter
    always_ff @(posedge clk) begin
        if (rst) begin
            hit_set   <= 1'b0;
            hit_clear <= 1'b0;
        end else begin
            hit_set   <= hit_set_next;
            hit_clear <= hit_clear_next;
        end
    end

endmodule // log_entry_matcher

// File: verilog/system_event_output_matcher.sv
// ======================================================================
// one configurable relay or digital output driven from the event log
//
// Contract
// - usage: disabled, command/status, event, data link
// - reject trigger codes unsupported for chosen parameter
// - oil pressure 100, codes 1,3,4,14,17
// - gas pressure 1390, codes 0,1,15,17
// - coolant temperature 110, codes 0,3,4,14,15,17
// - oil temperature 175, codes 0,1,15,17
// - exhaust temperature 173, codes 0,1,15,17
// - rear bearing temperature 1122, codes 0,1,15,17
// - winding temperature 1124, codes 0,15 only
// - levels 111, 98, 96, codes 0,1,15,17
// - external tank level 38, codes 0,1,15,17
// - any parameter: any logged number asserts
// - accessory link: only 1231 with code 11
// - charging voltage: only 167 with code 17
// - battery voltage 168, codes 0,15,17
// - auxiliary shutdown switch 970, codes 14,31
// - cooldown 4006, code 31 only
// - failure to start 1664, code 31 only
// - digital custom 701..708, code 31 only
// - analog custom 1083,1084,4158, codes 0,1,6,15,17
// - breaker open 4013, closed 4004, codes 6,31
// - current 2448, frequency 2436, power 2452
module system_event_output_matcher #(
    parameter int CNT_W = event_out_pkg::CNT_W  // active entry counter width
) (
    // clock and reset
    input  logic                               clk,
    input  logic                               rst,
    // configuration write
    input  logic                               cfg_wr,
    input  logic [1:0]                         cfg_usage,
    input  logic [event_out_pkg::PARAM_W-1:0]  cfg_param,
    input  logic [event_out_pkg::FMI_W-1:0]    cfg_fmi,
    // levels for the non-event usages
    input  logic                               cmd_status_level,
    input  logic                               scada_level,
    // event log entries
    input  logic                               log_valid,
    input  logic                               log_set,
    input  logic [event_out_pkg::SPN_W-1:0]    log_spn,
    input  logic [event_out_pkg::FMI_W-1:0]    log_fmi,
    // output pin level
    output logic                               out_drive,
    // configuration status
    output logic                               cfg_reject,
    output logic [1:0]                         cur_usage,
    output logic [event_out_pkg::PARAM_W-1:0]  cur_param,
    output logic [event_out_pkg::FMI_W-1:0]    cur_fmi,
    output logic                               event_active
);

    // ==================================================================
    // declarations
    logic [1:0]                        usage_reg, usage_next;
    logic [event_out_pkg::PARAM_W-1:0] param_reg, param_next;
    logic [event_out_pkg::FMI_W-1:0]   fmi_reg, fmi_next;
    logic                              reject_reg, reject_next;
    logic                              flush_reg, flush_next;   // counter clear
    logic                              drive_reg, drive_next;
    logic                              active_reg, active_next;

    logic [event_out_pkg::SPN_W-1:0]   req_spn;    // table: requested entry
    logic [31:0]                       req_mask;   // table: supported codes
    logic [event_out_pkg::SPN_W-1:0]   sel_spn;    // table: stored entry
    logic [31:0]                       sel_mask;
    logic                              req_ok;     // requested pair legal
    logic                              hit_set;
    logic                              hit_clear;
    logic [CNT_W-1:0]                  active_count;

    // ==================================================================
    // parameter table: number and supported trigger codes per entry
    function automatic void param_lookup(
        input  logic [event_out_pkg::PARAM_W-1:0] idx,
        output logic [event_out_pkg::SPN_W-1:0]   spn,
        output logic [31:0]                       mask
    );
        spn  = '0;
        mask = '0;
        case (idx)
            6'h00: begin spn = 19'h0_0064; mask = event_out_pkg::FM01 | event_out_pkg::FM03
                   | event_out_pkg::FM04 | event_out_pkg::FM14 | event_out_pkg::FM17; end
            6'h01: begin spn = 19'h0_056E; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM15 | event_out_pkg::FM17; end
            6'h02: begin spn = 19'h0_006E; mask = event_out_pkg::FM00 | event_out_pkg::FM03
                   | event_out_pkg::FM04 | event_out_pkg::FM14 | event_out_pkg::FM15
                   | event_out_pkg::FM17; end
            6'h03: begin spn = 19'h0_00AF; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM15 | event_out_pkg::FM17; end
            6'h04: begin spn = 19'h0_00AD; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM15 | event_out_pkg::FM17; end
            6'h05: begin spn = 19'h0_0462; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM15 | event_out_pkg::FM17; end
            6'h06: begin spn = 19'h0_0464;
                   mask = event_out_pkg::FM00 | event_out_pkg::FM15; end
            6'h07: begin spn = 19'h0_006F; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM15 | event_out_pkg::FM17; end
            6'h08: begin spn = 19'h0_0062; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM15 | event_out_pkg::FM17; end
            6'h09: begin spn = 19'h0_0060; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM15 | event_out_pkg::FM17; end
            6'h0A: begin spn = 19'h0_0026; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM15 | event_out_pkg::FM17; end
            // wildcard: any code is accepted and then ignored
            6'h0B: begin spn = '0; mask = 32'hFFFF_FFFF; end
            6'h0C: begin spn = 19'h0_04CF; mask = event_out_pkg::FM11; end
            6'h0D: begin spn = 19'h0_00A7; mask = event_out_pkg::FM17; end
            6'h0E: begin spn = 19'h0_00A8; mask = event_out_pkg::FM00 | event_out_pkg::FM15
                   | event_out_pkg::FM17; end
            6'h0F: begin spn = 19'h0_03CA;
                   mask = event_out_pkg::FM14 | event_out_pkg::FM31; end
            6'h10: begin spn = 19'h0_0FA6; mask = event_out_pkg::FM31; end
            6'h11: begin spn = 19'h0_0680; mask = event_out_pkg::FM31; end
            6'h12: begin spn = 19'h0_00BE; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM02 | event_out_pkg::FM05 | event_out_pkg::FM17; end
            6'h13: begin spn = 19'h0_0FA7; mask = event_out_pkg::FM31; end
            6'h14: begin spn = 19'h0_0990; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM15 | event_out_pkg::FM17; end
            6'h15: begin spn = 19'h0_0984; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM02 | event_out_pkg::FM12 | event_out_pkg::FM15
                   | event_out_pkg::FM17; end
            6'h16: begin spn = 19'h0_0994; mask = event_out_pkg::FM01 | event_out_pkg::FM15
                   | event_out_pkg::FM17; end
            6'h17: begin spn = 19'h0_0988; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM15 | event_out_pkg::FM17; end
            6'h18: begin spn = 19'h0_027F; mask = event_out_pkg::FM11; end
            6'h19: begin spn = 19'h0_0DFD; mask = event_out_pkg::FM11; end
            6'h1A: begin spn = 19'h0_0A58; mask = event_out_pkg::FM31; end
            6'h1B: begin spn = 19'h0_0567; mask = event_out_pkg::FM11; end
            6'h1C: begin spn = 19'h0_0FBC; mask = event_out_pkg::FM31; end
            6'h1D: begin spn = 19'h0_0FBD; mask = event_out_pkg::FM31; end
            6'h1E: begin spn = 19'h0_0DD7; mask = event_out_pkg::FM09; end
            6'h1F: begin spn = 19'h0_04D7; mask = event_out_pkg::FM31; end
            6'h20: begin spn = 19'h0_0FA0; mask = event_out_pkg::FM31; end
            6'h21: begin spn = 19'h0_0FA3; mask = event_out_pkg::FM31; end
            6'h22: begin spn = 19'h0_0FAD;
                   mask = event_out_pkg::FM06 | event_out_pkg::FM31; end
            6'h23: begin spn = 19'h0_0FA4;
                   mask = event_out_pkg::FM06 | event_out_pkg::FM31; end
            // digital input custom events, one number per input
            6'h24: begin spn = 19'h0_02BD; mask = event_out_pkg::FM31; end
            6'h25: begin spn = 19'h0_02BE; mask = event_out_pkg::FM31; end
            6'h26: begin spn = 19'h0_02BF; mask = event_out_pkg::FM31; end
            6'h27: begin spn = 19'h0_02C0; mask = event_out_pkg::FM31; end
            6'h28: begin spn = 19'h0_02C1; mask = event_out_pkg::FM31; end
            6'h29: begin spn = 19'h0_02C2; mask = event_out_pkg::FM31; end
            6'h2A: begin spn = 19'h0_02C3; mask = event_out_pkg::FM31; end
            6'h2B: begin spn = 19'h0_02C4; mask = event_out_pkg::FM31; end
            // analog input custom parameters
            6'h2C: begin spn = 19'h0_043B; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM06 | event_out_pkg::FM15 | event_out_pkg::FM17; end
            6'h2D: begin spn = 19'h0_043C; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM06 | event_out_pkg::FM15 | event_out_pkg::FM17; end
            6'h2E: begin spn = 19'h0_103E; mask = event_out_pkg::FM00 | event_out_pkg::FM01
                   | event_out_pkg::FM06 | event_out_pkg::FM15 | event_out_pkg::FM17; end
            // unused selector codes: empty mask, so never selectable
            default: begin spn = '0; mask = '0; end
        endcase
    endfunction

    // ==================================================================
    // table reads for the requested and the stored selection
    always_comb begin
        param_lookup(cfg_param, req_spn, req_mask);
        param_lookup(param_reg, sel_spn, sel_mask);
        // legal only when the requested code has its bit in the mask
        req_ok = (cfg_param < event_out_pkg::PARAM_COUNT) && req_mask[cfg_fmi];
    end

    // ==================================================================
    // configuration store: a system event write with an unsupported
    // pair is refused whole, so the old selection keeps working
    always_comb begin
        usage_next  = usage_reg;
        param_next  = param_reg;
        fmi_next    = fmi_reg;
        reject_next = 1'b0;
        flush_next  = 1'b0;
        if (cfg_wr) begin
            if (cfg_usage != event_out_pkg::USAGE_SYS_EVENT) begin
                // other usages carry no event selection
                usage_next = cfg_usage;
                flush_next = 1'b1;
            end else if (req_ok) begin
                usage_next = cfg_usage;
                param_next = cfg_param;
                fmi_next   = cfg_fmi;
                flush_next = 1'b1;
            end else begin
                reject_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            usage_reg  <= event_out_pkg::RST_USAGE;
            param_reg  <= event_out_pkg::RST_PARAM;
            fmi_reg    <= event_out_pkg::RST_FMI;
            reject_reg <= 1'b0;
            flush_reg  <= 1'b0;
        end else begin
            usage_reg  <= usage_next;
            param_reg  <= param_next;
            fmi_reg    <= fmi_next;
            reject_reg <= reject_next;
            flush_reg  <= flush_next;
        end
    end

    // ==================================================================
    // entry compare; matching is armed only for the system event usage
    log_entry_matcher #(
        .SPN_W (event_out_pkg::SPN_W),
        .FMI_W (event_out_pkg::FMI_W)
    ) u_match (
        .clk       (clk),
        .rst       (rst),
        .armed     (usage_reg == event_out_pkg::USAGE_SYS_EVENT),
        .any_spn   (param_reg == event_out_pkg::ANY_SPN_INDEX),
        .sel_spn   (sel_spn),
        .sel_fmi   (fmi_reg),
        .log_valid (log_valid),
        .log_set   (log_set),
        .log_spn   (log_spn),
        .log_fmi   (log_fmi),
        .hit_set   (hit_set),
        .hit_clear (hit_clear)
    );

    // ==================================================================
    // active entry count; entries logged before a change are forgotten,
    // since their clears would no longer match the new selection
    active_event_counter #(
        .CNT_W (CNT_W)
    ) u_count (
        .clk   (clk),
        .rst   (rst),
        .flush (flush_reg),
        .up    (hit_set),
        .down  (hit_clear),
        .count (active_count)
    );

    // ==================================================================
    // pin level per usage
    always_comb begin
        active_next = (active_count != '0);
        case (usage_reg)
            event_out_pkg::USAGE_SYS_EVENT:  drive_next = active_next;
            event_out_pkg::USAGE_CMD_STATUS: drive_next = cmd_status_level;
            event_out_pkg::USAGE_SCADA:      drive_next = scada_level;
            default:                         drive_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            drive_reg  <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            drive_reg  <= drive_next;
            active_reg <= active_next;
        end
    end

    // ==================================================================
    // outputs, all straight from flops
    assign out_drive    = drive_reg;
    assign cfg_reject   = reject_reg;
    assign cur_usage    = usage_reg;
    assign cur_param    = param_reg;
    assign cur_fmi      = fmi_reg;
    assign event_active = active_reg;

endmodule // system_event_output_matcher
